// ===== logic/kpm_map.svh
`ifndef KPM_MAP_SVH
`define KPM_MAP_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define KPM_CLK_HZ 125000000
`define KPM_HOLD_MS 2000
`define KPM_IDLE_S 300
`define KPM_DEB_MS 10
`define KPM_PWM_MS 1000
`define KPM_DUTY_LO 15
`define KPM_DUTY_HI 85
// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define KPM_CTRL_OFS 8'h00
`define KPM_STAT_OFS 8'h04
`define KPM_WORK_OFS 8'h08
`define KPM_SAVE_OFS 8'h0C
`define KPM_KEY_OFS 8'h10
`define KPM_CTRL_ROLE 0
`define KPM_CTRL_SAFECLR 1
// ----------------------------------------
// reset values and answers
// ----------------------------------------
`define KPM_SET_DEF 10'h200
`define KPM_PASS_DEF 16'h0000
`define KPM_RESP_OK 2'h0
`define KPM_RESP_ERR 2'h2
`endif

// ===== logic/kpm_pkg.sv
package kpm_pkg;
  typedef struct packed {
    logic apply;
    logic up;
    logic down;
  } kpm_keys_s;

  typedef struct packed {
    logic range_high;
    logic blanking;
    logic mute_dur_8h;
    logic [2:0] beam_suppression_item;
    logic chaining_item;
    logic beam_coding;
    logic contactor_monitoring;
    logic restart_inhibit;
  } kpm_set_s;

  typedef enum logic [3:0] {
    ST_RUN = 4'h0,
    ST_E1_HOLD = 4'h1,
    ST_E1_REL = 4'h2,
    ST_E_GAP = 4'h3,
    ST_E2_HOLD = 4'h4,
    ST_E2_REL = 4'h5,
    ST_PASS = 4'h6,
    ST_RMENU = 4'h7,
    ST_ROPT = 4'h8,
    ST_SHOW = 4'h9,
    ST_EMENU = 4'hA,
    ST_EACK = 4'hB,
    ST_LAMP = 4'hC,
    ST_SAFE = 4'hD,
    ST_E_READY = 4'hE
  } kpm_state_e;

  typedef enum logic [2:0] {
    IT_RES = 3'h0,
    IT_EDM = 3'h1,
    IT_CODE = 3'h2,
    IT_CHAINING_ITEM = 3'h3,
    IT_BEAM_SUPPRESSION_ITEM = 3'h4,
    IT_SAVE = 3'h5,
    IT_EXIT = 3'h6
  } kpm_item_e;

  typedef struct packed {
    logic err_led;
    logic range_led;
    logic code_led;
    logic opt_flash;
    logic [3:0] digit_flash;
    logic [3:0] digit_val;
    logic [1:0] level;
    logic [2:0] item;
    logic [2:0] option;
    logic safe;
  } kpm_disp_s;

  typedef struct packed {
    logic session;
    logic err;
    logic unlock;
    logic [2:0] opt;
    logic [2:0] item;
    logic [3:0] state;
  } kpm_stat_s;
endpackage

// ===== logic/kpm_top.sv
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "kpm_map.svh"
module kpm_top import kpm_pkg::*; #(
  parameter int DEB_CYC = `KPM_DEB_MS * (`KPM_CLK_HZ / 1000),
  parameter int HOLD_CYC = `KPM_HOLD_MS * (`KPM_CLK_HZ / 1000),
  parameter int PWM_CYC = `KPM_PWM_MS * (`KPM_CLK_HZ / 1000),
  parameter longint IDLE_CYC = 64'(`KPM_IDLE_S) * `KPM_CLK_HZ
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire kpm_keys_s keys_in,
  input wire logic error_mode_in,
  output kpm_disp_s disp_out,
  output logic [1:0] safety_switch_output_out,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out
);
  // ----------------------------------------
  // constants and helpers
  // ----------------------------------------
  localparam logic [20:0] DEB_LAST = 21'(DEB_CYC - 1);
  localparam logic [27:0] HOLD_LAST = 28'(HOLD_CYC - 1);
  localparam logic [26:0] PWM_LAST = 27'(PWM_CYC - 1);
  localparam logic [26:0] PWM_HALF = 27'(PWM_CYC / 2);
  localparam logic [26:0] DUTY_LO =
    27'(longint'(PWM_CYC) * `KPM_DUTY_LO / 100);
  localparam logic [26:0] DUTY_HI =
    27'(longint'(PWM_CYC) * `KPM_DUTY_HI / 100);
  localparam logic [35:0] IDLE_LAST = 36'(IDLE_CYC - 1);
  localparam kpm_set_s SET_DEF = `KPM_SET_DEF;
  localparam logic [15:0] PASS_CODE = `KPM_PASS_DEF;

  // 0..4 for mapped words, 7 for anything else
  function automatic logic [2:0] reg_idx(logic [31:0] a);
    logic [2:0] r;
    r = 3'h7;
    if (a[31:8] == 24'h0) begin
      unique case (a[7:0])
        `KPM_CTRL_OFS: r = 3'h0;
        `KPM_STAT_OFS: r = 3'h1;
        `KPM_WORK_OFS: r = 3'h2;
        `KPM_SAVE_OFS: r = 3'h3;
        `KPM_KEY_OFS: r = 3'h4;
        default: r = 3'h7;
      endcase
    end
    return r;
  endfunction

  function automatic logic [3:0] dstep(logic [3:0] d, logic inc);
    if (inc) begin
      return (d == 4'h9) ? 4'h0 : 4'(d + 4'h1);
    end
    return (d == 4'h0) ? 4'h9 : 4'(d - 4'h1);
  endfunction

  // option 0 = on, 1 = off; beam suppression takes its mode code directly
  function automatic kpm_set_s pick(kpm_set_s s, logic [2:0] it,
                                    logic [2:0] op);
    kpm_set_s r;
    r = s;
    unique case (it)
      IT_RES: begin
        r.restart_inhibit = (op == 3'h0);
        if (op != 3'h0) begin
          r.beam_suppression_item = 3'h0;
        end
      end
      IT_EDM: r.contactor_monitoring = (op == 3'h0);
      IT_CODE: r.beam_coding = (op == 3'h0);
      IT_CHAINING_ITEM: begin
        r.chaining_item = (op == 3'h0);
        if (op == 3'h0 && s.beam_suppression_item >= 3'h3) begin
          r.beam_suppression_item = 3'h0;
        end
      end
      IT_BEAM_SUPPRESSION_ITEM: begin
        r.beam_suppression_item = op;
        if (op != 3'h0) begin
          r.restart_inhibit = 1'b1;
        end
        if (op >= 3'h3) begin
          r.chaining_item = 1'b0;
        end
      end
      default: r = s;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------
  logic rst_s1, rst_n;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  logic err_s1, err_s;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      err_s1 <= 1'b0;
      err_s <= 1'b0;
    end else begin
      err_s1 <= error_mode_in;
      err_s <= err_s1;
    end
  end

  wire [2:0] key_raw = 3'(keys_in);
  logic ks1 [0:2];
  logic ks2 [0:2];
  logic kdb [0:2];
  logic [20:0] dcnt [0:2];
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_deb
      always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
          ks1[g] <= 1'b0;
          ks2[g] <= 1'b0;
          kdb[g] <= 1'b0;
          dcnt[g] <= 21'h0;
        end else begin
          ks1[g] <= key_raw[g];
          ks2[g] <= ks1[g];
          if (ks2[g] == kdb[g]) begin
            dcnt[g] <= 21'h0;
          end else if (dcnt[g] == DEB_LAST) begin
            kdb[g] <= ks2[g];
            dcnt[g] <= 21'h0;
          end else begin
            dcnt[g] <= 21'(dcnt[g] + 21'h1);
          end
        end
      end
    end
  endgenerate

  wire [2:0] kd = {kdb[2], kdb[1], kdb[0]};
  logic [2:0] kprev;
  wire [2:0] press = kd & ~kprev;
  wire key_chg = |(kd ^ kprev);
  wire both_held = kd[0] & kd[2];

  // ----------------------------------------
  // register bus decode
  // ----------------------------------------
  kpm_state_e state, next_state;
  logic aw_full, w_full, role;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  logic unlock, next_unlock;
  kpm_set_s work, saved, pend, next_work, next_saved, next_pend;

  wire wr_fire = aw_full & w_full & ~s_axi_bvalid_out;
  wire [2:0] wr_idx = reg_idx(awaddr_q);
  wire [2:0] rd_idx = reg_idx(s_axi_araddr_in);
  wire lanes_lo = &wstrb_q[1:0];
  wire in_run = (state == ST_RUN);
  wire rem_ok = in_run & unlock;
  wire rem_work = wr_fire & (wr_idx == 3'h2) & rem_ok & lanes_lo;
  wire rem_key = wr_fire & (wr_idx == 3'h4) & in_run & lanes_lo;
  wire safe_clr = wr_fire & (wr_idx == 3'h0) & wstrb_q[0] &
                  wdata_q[`KPM_CTRL_SAFECLR];
  wire wr_err = (wr_idx == 3'h7) | ((wr_idx == 3'h2) & ~rem_ok) |
                ((wr_idx == 3'h4) & ~in_run);
  wire session = (state == ST_PASS) | (state == ST_RMENU) |
                 (state == ST_ROPT) | (state == ST_SHOW) |
                 (state == ST_EMENU) | (state == ST_EACK);
  logic [2:0] item, opt, next_item, next_opt;
  kpm_stat_s stat;
  assign stat = '{session: session, err: err_s, unlock: unlock,
                  opt: opt, item: item, state: state};
  logic [31:0] rd_mux;
  always_comb begin
    unique case (rd_idx)
      3'h0: rd_mux = {31'h0, role};
      3'h1: rd_mux = 32'(stat);
      3'h2: rd_mux = 32'(work);
      3'h3: rd_mux = 32'(saved);
      default: rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------
  // register bus slave
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `KPM_RESP_OK;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= `KPM_RESP_OK;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      role <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_full <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end else if (!aw_full) begin
        s_axi_awready_out <= 1'b1;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_full <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end else if (!w_full) begin
        s_axi_wready_out <= 1'b1;
      end
      if (wr_fire) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_err ? `KPM_RESP_ERR : `KPM_RESP_OK;
        if (wr_idx == 3'h0 && wstrb_q[0]) begin
          role <= wdata_q[`KPM_CTRL_ROLE];
        end
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        aw_full <= 1'b0;
        w_full <= 1'b0;
      end
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_mux;
        s_axi_rresp_out <= (rd_idx == 3'h7) ? `KPM_RESP_ERR
                                            : `KPM_RESP_OK;
      end else if (!s_axi_rvalid_out) begin
        s_axi_arready_out <= 1'b1;
      end
      if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // timers
  // ----------------------------------------
  logic [27:0] tmr;
  logic [35:0] icnt;
  logic [26:0] pcnt;
  wire tdone = (tmr == HOLD_LAST);
  wire idle_done = (icnt == IDLE_LAST);
  wire blink = (pcnt < PWM_HALF);

  // ----------------------------------------
  // menu sequencer
  // ----------------------------------------
  logic [15:0] ent, next_ent;
  logic [1:0] pos, next_pos;
  wire [3:0] cur_dig = ent[{pos, 2'b00} +: 4];
  wire [2:0] opt_last = (item == IT_BEAM_SUPPRESSION_ITEM) ? 3'h5 : 3'h2;

  always_comb begin
    next_state = state;
    next_work = work;
    next_saved = saved;
    next_pend = pend;
    next_ent = ent;
    next_pos = pos;
    next_item = item;
    next_opt = opt;
    next_unlock = unlock;
    if (rem_key) begin
      next_unlock = (wdata_q[15:0] == PASS_CODE);
    end
    if (rem_work) begin
      next_work = kpm_set_s'(wdata_q[9:0]);
      next_saved = kpm_set_s'(wdata_q[9:0]);
    end
    unique case (state)
      ST_RUN: begin
        if (press[0]) begin
          next_state = ST_E1_HOLD;
        end
      end
      ST_E1_HOLD: begin
        if (!kd[0]) begin
          next_state = ST_RUN;
        end else if (tdone) begin
          next_state = ST_E1_REL;
        end
      end
      ST_E1_REL: begin
        if (!kd[0]) begin
          next_state = ST_E_GAP;
        end
      end
      ST_E_GAP: begin
        if (tdone) begin
          next_state = ST_E_READY;
        end
      end
      ST_E_READY: begin
        if (press[0]) begin
          next_state = ST_E2_HOLD;
        end else if (tdone) begin
          next_state = ST_RUN;
        end
      end
      ST_E2_HOLD: begin
        if (!kd[0]) begin
          next_state = ST_RUN;
        end else if (tdone) begin
          next_state = ST_E2_REL;
        end
      end
      ST_E2_REL: begin
        if (!kd[0]) begin
          next_state = ST_PASS;
          next_unlock = 1'b0;
          next_ent = 16'h0;
          next_pos = 2'h0;
          next_item = 3'h0;
          next_opt = 3'h0;
          if (err_s) begin
            next_work = SET_DEF;
          end
          next_pend = err_s ? SET_DEF : work;
        end
      end
      ST_PASS: begin
        if (press[1] || press[0]) begin
          next_ent[{pos, 2'b00} +: 4] = dstep(cur_dig, press[1] | ~role);
        end else if (press[2]) begin
          next_pos = 2'(pos + 2'h1);
          if (pos == 2'h3) begin
            if (ent == PASS_CODE) begin
              next_state = role ? ST_RMENU : ST_EMENU;
            end else begin
              next_ent = 16'h0;
            end
          end
        end
      end
      ST_RMENU: begin
        if (press[0]) begin
          next_item = (item == IT_EXIT) ? 3'h0 : 3'(item + 3'h1);
        end else if (press[1]) begin
          next_item = (item == 3'h0) ? IT_EXIT : 3'(item - 3'h1);
        end else if (press[2]) begin
          next_opt = 3'h0;
          if (item == IT_SAVE) begin
            next_saved = work;
            next_state = ST_RUN;
          end else if (item == IT_EXIT) begin
            next_state = ST_RUN;
          end else begin
            next_state = ST_ROPT;
          end
        end
      end
      ST_ROPT: begin
        if (press[0]) begin
          next_opt = (opt == opt_last) ? 3'h0 : 3'(opt + 3'h1);
        end else if (press[1]) begin
          next_opt = (opt == 3'h0) ? opt_last : 3'(opt - 3'h1);
        end else if (press[2]) begin
          if (opt == opt_last) begin
            next_state = ST_RMENU;
          end else begin
            next_work = pick(work, item, opt);
            next_state = ST_SHOW;
          end
        end
      end
      ST_SHOW: begin
        if (tdone) begin
          next_state = ST_RMENU;
        end
      end
      ST_EMENU: begin
        if (both_held) begin
          next_state = ST_EACK;
        end else if (press[0]) begin
          next_item = {2'b00, ~item[0]};
        end else if (press[2]) begin
          if (item[0]) begin
            next_pend.beam_coding = ~pend.beam_coding;
          end else begin
            next_pend.range_high = ~pend.range_high;
          end
        end
      end
      ST_EACK: begin
        if (!both_held) begin
          next_state = ST_EMENU;
        end else if (tdone) begin
          next_saved = pend;
          next_work = pend;
          next_state = ST_LAMP;
        end
      end
      ST_LAMP: begin
        if (tdone) begin
          next_state = ST_RUN;
        end
      end
      ST_SAFE: begin
        if (safe_clr) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
    if (session && idle_done) begin
      next_state = ST_SAFE;
      next_work = saved;
    end
  end

  // ----------------------------------------
  // indication
  // ----------------------------------------
  wire emenu = (state == ST_EMENU);
  wire lamp = (state == ST_LAMP);
  wire rng_duty = (pcnt < (pend.range_high ? DUTY_HI : DUTY_LO));
  wire cod_duty = (pcnt < (pend.beam_coding ? DUTY_HI : DUTY_LO));
  wire err_lit = (state == ST_RUN) ? err_s :
                 ~((state == ST_E1_REL) | (state == ST_E_GAP) |
                   (state == ST_E2_REL) | session & ~(state == ST_EACK));
  kpm_disp_s next_disp;
  assign next_disp = '{
    err_led: err_lit | lamp,
    range_led: emenu ? (~item[0] & rng_duty)
                     : lamp | (in_run & work.range_high),
    code_led: emenu ? (item[0] & cod_duty)
                    : lamp | (in_run & work.beam_coding),
    opt_flash: (state == ST_ROPT) & blink,
    digit_flash: (state == ST_PASS) ?
                 (4'(4'h1 << pos) & {4{blink}}) : 4'h0,
    digit_val: (state == ST_PASS) ? cur_dig : 4'h0,
    level: (state == ST_ROPT || state == ST_SHOW) ? 2'h1 : 2'h0,
    item: item,
    option: opt,
    safe: (state == ST_SAFE)};
  // outputs only enabled in plain run mode without an error
  wire safety_switch_output_ok = in_run & ~err_s;

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RUN;
      work <= SET_DEF;
      saved <= SET_DEF;
      pend <= SET_DEF;
      ent <= 16'h0;
      pos <= 2'h0;
      item <= 3'h0;
      opt <= 3'h0;
      unlock <= 1'b0;
      kprev <= 3'h0;
      tmr <= 28'h0;
      icnt <= 36'h0;
      pcnt <= 27'h0;
      disp_out <= '0;
      safety_switch_output_out <= 2'b00;
    end else begin
      state <= next_state;
      work <= next_work;
      saved <= next_saved;
      pend <= next_pend;
      ent <= next_ent;
      pos <= next_pos;
      item <= next_item;
      opt <= next_opt;
      unlock <= next_unlock;
      kprev <= kd;
      tmr <= (next_state != state) ? 28'h0
           : (tdone ? tmr : 28'(tmr + 28'h1));
      // any key edge or bus write counts as activity
      icnt <= (!session || key_chg || wr_fire) ? 36'h0
            : 36'(icnt + 36'h1);
      pcnt <= (pcnt == PWM_LAST) ? 27'h0 : 27'(pcnt + 27'h1);
      disp_out <= next_disp;
      safety_switch_output_out <= {2{safety_switch_output_ok}};
    end
  end
endmodule

// ===== sim/kpm_top_sva.sv
`timescale 1ns/1ps
module kpm_top_sva import kpm_pkg::*; #(
  parameter longint IDLE_CYC = 200
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire kpm_keys_s keys_in,
  input wire logic error_mode_in,
  input wire kpm_disp_s disp_out,
  input wire logic [1:0] safety_switch_output_out,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out
);
  // ----
  // quiet-time counter
  // ----
  // restarts on raw key change, error mode input or bus write address; margin covers debounce lag
  kpm_keys_s keys_q;
  logic [31:0] idle;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      keys_q <= '0;
      idle <= '0;
    end else begin
      keys_q <= keys_in;
      if (keys_in != keys_q || error_mode_in || s_axi_awvalid_in) begin
        idle <= '0;
      end else if (idle != 32'hFFFFFFFF) begin
        idle <= idle + 32'h1;
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_outs_paired:
    assert property (safety_switch_output_out inside {2'h0, 2'h3})
    else $error("safety outputs disagree");
  a_err_outs_off:
    assert property (error_mode_in [*5] |->
      safety_switch_output_out == 2'h0)
    else $error("safety outputs on in error mode");
  a_safe_outs_off:
    assert property (disp_out.safe |-> safety_switch_output_out == 2'h0)
    else $error("safety outputs on in safe state");
  a_idle_safe:
    assert property (idle > 32'(IDLE_CYC) + 32'd40 |->
      disp_out.safe || safety_switch_output_out == 2'h3)
    else $error("session outlived the quiet time");
  a_b_timing:
    assert property (s_axi_awvalid_in && s_axi_awready_out &&
      s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
    else $error("write response late");
  a_r_timing:
    assert property (s_axi_arvalid_in && s_axi_arready_out |=>
      s_axi_rvalid_out)
    else $error("read data late");
  a_aw_return:
    assert property (s_axi_bvalid_out && s_axi_bready_in |->
      ##[1:2] (s_axi_awready_out && s_axi_wready_out))
    else $error("write channels not ready again");
  a_ar_return:
    assert property (s_axi_rvalid_out && s_axi_rready_in |->
      ##[1:2] s_axi_arready_out)
    else $error("read channel not ready again");
  a_rerr_zero:
    assert property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2 |->
      s_axi_rdata_out == 32'h0)
    else $error("refused read returned data");
endmodule

bind kpm_top kpm_top_sva #(.IDLE_CYC(IDLE_CYC)) kpm_top_sva_i (
  .clk_in, .nrst_in, .keys_in, .error_mode_in, .disp_out,
  .safety_switch_output_out, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
  .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out);

// ===== sim/kpm_key_model.sv
`timescale 1ns/1ps
module kpm_key_model import kpm_pkg::*; (
  input wire logic clk_in,
  input wire logic err_led_in,
  output kpm_keys_s keys_out
);
  // released buttons read low
  initial keys_out = '0;
  task automatic tap(input kpm_keys_s k, input int n);
    @(posedge clk_in);
    keys_out <= k;
    repeat (n) @(posedge clk_in);
    keys_out <= '0;
    repeat (n) @(posedge clk_in);
  endtask
  // hold until the red lamp has lit and gone out, then let go
  task automatic hold_led(input kpm_keys_s k, output int n);
    n = 0;
    @(posedge clk_in);
    keys_out <= k;
    while (!err_led_in && n < 99) begin
      @(posedge clk_in);
      n++;
    end
    while (err_led_in && n < 99) begin
      @(posedge clk_in);
      n++;
    end
    keys_out <= '0;
  endtask
endmodule

// ===== sim/tb_keypad_parameter_menu.sv
`timescale 1ns/1ps
`include "kpm_map.svh"
module tb_keypad_parameter_menu import kpm_pkg::*;;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [1:0] r;
  } kpm_row_s;
  localparam kpm_row_s ROWS [5] = '{
    '{`KPM_STAT_OFS, 32'h0, `KPM_RESP_OK},
    '{`KPM_WORK_OFS, 32'h200, `KPM_RESP_OK},
    '{`KPM_SAVE_OFS, 32'h200, `KPM_RESP_OK},
    '{8'h14, 32'h0, `KPM_RESP_ERR},
    '{8'hFC, 32'h0, `KPM_RESP_ERR}};
  logic clk_in, nrst_in, error_mode_in;
  kpm_keys_s keys;
  kpm_disp_s disp;
  logic [1:0] sso, bresp, rresp;
  logic awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [31:0] awa, wd, ara, rdat;
  logic [3:0] strb;
  logic [2:0] prot;
  int n_mismatch, total_checks, lit;
  kpm_top #(.DEB_CYC(4), .HOLD_CYC(20), .PWM_CYC(20), .IDLE_CYC(200))
  kpm_top_i (
    .clk_in, .nrst_in, .keys_in(keys), .error_mode_in,
    .disp_out(disp), .safety_switch_output_out(sso),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
    .s_axi_awprot_in(prot), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(strb), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(br), .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_arprot_in(prot),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rresp));
  kpm_key_model kpm_key_model_i (
    .clk_in, .err_led_in(disp.err_led), .keys_out(keys));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // ----
  // checking and bus tasks
  // ----
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 99) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_in);
    awa <= {24'h0, a};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv && n < 99);
    br <= 1'b0;
    tmo(n);
    chk(bresp, er);
  endtask
  // masks limit the compare to the fields a check is about, such as the state code or the settings bits
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_in);
    ara <= {24'h0, a};
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 99);
    rr <= 1'b0;
    tmo(n);
    chk(rdat & m, e);
    chk(rresp, er);
  endtask
  task automatic enter();
    int n;
    kpm_key_model_i.hold_led(3'h1, n);
    tmo(n);
    n = 0;
    while (!disp.err_led && n < 99) begin
      @(posedge clk_in);
      n++;
    end
    tmo(n);
    kpm_key_model_i.hold_led(3'h1, n);
    tmo(n);
    // release still has to pass debounce before the password menu opens
    repeat (12) @(posedge clk_in);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    nrst_in = 1'b0;
    error_mode_in = 1'b0;
    {awv, wv, br, arv, rr} = 5'h0;
    strb = 4'hF;
    prot = 3'h0;
    {awa, wd, ara} = 96'h0;
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(sso, 2'h3);
    foreach (ROWS[i]) begin
      rdchk(ROWS[i].a, 32'hFFFFFFFF, ROWS[i].d, ROWS[i].r);
    end
    bus_wr(`KPM_WORK_OFS, 32'h1, `KPM_RESP_ERR);
    bus_wr(`KPM_KEY_OFS, 32'h0, `KPM_RESP_OK);
    bus_wr(`KPM_WORK_OFS, 32'h1, `KPM_RESP_OK);
    strb <= 4'h4;
    bus_wr(`KPM_WORK_OFS, 32'h200, `KPM_RESP_OK);
    strb <= 4'hF;
    rdchk(`KPM_SAVE_OFS, 32'h3FF, 32'h1, `KPM_RESP_OK);
    bus_wr(`KPM_WORK_OFS, 32'h200, `KPM_RESP_OK);
    bus_wr(`KPM_CTRL_OFS, 32'h1, `KPM_RESP_OK);
    enter();
    rdchk(`KPM_STAT_OFS, 32'hF, 32'h6, `KPM_RESP_OK);
    chk(sso, 2'h0);
    repeat (4) kpm_key_model_i.tap(3'h4, 10);
    rdchk(`KPM_STAT_OFS, 32'hF, 32'h7, `KPM_RESP_OK);
    bus_wr(`KPM_WORK_OFS, 32'h1, `KPM_RESP_ERR);
    kpm_key_model_i.tap(3'h1, 10);
    rdchk(`KPM_STAT_OFS, 32'h7F, 32'h17, `KPM_RESP_OK);
    kpm_key_model_i.tap(3'h2, 10);
    rdchk(`KPM_STAT_OFS, 32'h7F, 32'h07, `KPM_RESP_OK);
    repeat (250) @(posedge clk_in);
    rdchk(`KPM_STAT_OFS, 32'hF, 32'hD, `KPM_RESP_OK);
    chk(sso, 2'h0);
    rdchk(`KPM_WORK_OFS, 32'h3FF, 32'h200, `KPM_RESP_OK);
    bus_wr(`KPM_CTRL_OFS, 32'h3, `KPM_RESP_OK);
    repeat (4) @(posedge clk_in);
    chk(sso, 2'h3);
    bus_wr(`KPM_KEY_OFS, 32'h0, `KPM_RESP_OK);
    bus_wr(`KPM_WORK_OFS, 32'h1, `KPM_RESP_OK);
    error_mode_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    enter();
    rdchk(`KPM_STAT_OFS, 32'hF, 32'h6, `KPM_RESP_OK);
    rdchk(`KPM_WORK_OFS, 32'h3FF, 32'h200, `KPM_RESP_OK);
    error_mode_in <= 1'b0;
    // password, then item 0 opened and its first option picked
    repeat (6) kpm_key_model_i.tap(3'h4, 10);
    repeat (12) @(posedge clk_in);
    rdchk(`KPM_STAT_OFS, 32'h7F, 32'h07, `KPM_RESP_OK);
    rdchk(`KPM_WORK_OFS, 32'h3FF, 32'h201, `KPM_RESP_OK);
    rdchk(`KPM_SAVE_OFS, 32'h3FF, 32'h1, `KPM_RESP_OK);
    repeat (2) kpm_key_model_i.tap(3'h2, 10);
    kpm_key_model_i.tap(3'h4, 10);
    rdchk(`KPM_SAVE_OFS, 32'h3FF, 32'h201, `KPM_RESP_OK);
    bus_wr(`KPM_CTRL_OFS, 32'h0, `KPM_RESP_OK);
    enter();
    repeat (5) kpm_key_model_i.tap(3'h4, 10);
    lit = 0;
    repeat (20) begin
      @(posedge clk_in);
      lit += disp.range_led;
    end
    chk(lit, 20 * `KPM_DUTY_LO / 100);
    kpm_key_model_i.tap(3'h1, 10);
    kpm_key_model_i.tap(3'h4, 10);
    kpm_key_model_i.hold_led(3'h5, lit);
    tmo(lit);
    rdchk(`KPM_SAVE_OFS, 32'h3FF, 32'h005, `KPM_RESP_OK);
    chk(disp.code_led, 1'b1);
    summarize();
  end
endmodule
